// ===== design/row_cache_ctrl.sv
// Controller that drives a banked row-cache memory through its pins
// ***************************************
// What this block does
// - An output data latch may be engaged to hold read data longer.
// - Column strobe held high on a read gives static column mode.
// - Column strobe low latches the column until change and return high.
// - A dedicated output enable gates the data outputs.
// - Read starts with row strobe low, write select low, refresh high.
// - A write happens only while column strobe and write enable are low.
// ***************************************
module row_cache_ctrl
   import row_cache_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // User requests
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [DATA_W-1:0] RSP_RDATA,
   // Maintenance
   input wire logic REFRESH_REQ,
   input wire logic EDO_EN,
   output logic REFRESH_ACK,
   // Device pins
   output logic SEL_N,
   output logic ROW_STROBE_N,
   output logic WR_SEL,
   output logic CAL_N,
   output logic WE_N,
   output logic REFRESH_N,
   output logic OE_N,
   output logic LATCH_EN,
   output logic [ROW_W-1:0] ADDR,
   output logic [DATA_W-1:0] DQ_OUT,
   output logic DQ_OE,
   input wire logic [DATA_W-1:0] DQ_IN,
   input wire logic HIT_N
);

   // ***************************************
   // Reset release
   // ***************************************
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   assign rst_n = rst_sync_reg[1];

   // ***************************************
   // Row tracker
   // ***************************************
   row_track_if trk ();

   row_tracker u_tracker (
      .clk (REF_CLK),
      .rst_n (rst_n),
      .trk (trk)
   );

   // ***************************************
   // Sequencer
   // ***************************************
   state_e state_reg;
   state_e state_next;
   cnt_t cnt_reg;
   cnt_t cnt_next;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;
   logic write_reg;
   logic write_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic rsp_reg;
   logic rsp_next;
   logic ack_reg;
   logic ack_next;
   pins_s pin_reg;
   pins_s pin_next;
   logic page_match;
   logic fast;
   logic take;
   logic load;
   row_t cur_row;

   assign cur_row = addr_reg[ADDR_W-1:ROW_LO];
   assign trk.bank = bank_of(cur_row);
   assign trk.row = latch_of(cur_row);
   assign trk.load = load;
   // Trust a hit only when both the device and our mirror agree
   assign fast = trk.hit && !HIT_N;
   assign page_match = REQ_WRITE == write_reg &&
      REQ_ADDR[ADDR_W-1:ROW_LO] == cur_row;
   assign REQ_READY = (state_reg == ST_IDLE && !REFRESH_REQ) ||
      (state_reg == ST_PAGE && page_match);
   assign take = REQ_VALID && REQ_READY;

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      write_next = write_reg;
      rdata_next = rdata_reg;
      rsp_next = 1'b0;
      ack_next = 1'b0;
      pin_next = pin_reg;
      load = 1'b0;
      if (cnt_reg != 3'h0)
         cnt_next = cnt_reg - 3'h1;
      case (state_reg)
         ST_IDLE:
         begin
            pin_next = PINS_IDLE;
            if (REFRESH_REQ)
            begin
               state_next = ST_REFRESH;
               cnt_next = MISS_LD;
               pin_next.ref_n = 1'b0;
               pin_next.row_strobe_n = 1'b0;
            end
            else if (take)
            begin
               state_next = ST_ROW;
               cnt_next = HV_LD;
               addr_next = REQ_ADDR;
               wdata_next = REQ_WDATA;
               write_next = REQ_WRITE;
               pin_next.sel_n = 1'b0;
               pin_next.row_strobe_n = 1'b0;
               pin_next.wr = REQ_WRITE;
               pin_next.addr = REQ_ADDR[ADDR_W-1:ROW_LO];
            end
         end
         ST_ROW:
         begin
            if (cnt_reg == 3'h0)
            begin
               pin_next.addr = {3'h0, addr_reg[COL_W-1:0]};
               if (write_reg)
               begin
                  state_next = ST_WRITE;
                  cnt_next = CACHE_LD;
                  pin_next.dq = wdata_reg;
                  pin_next.dq_oe = 1'b1;
                  pin_next.cal_n = 1'b0;
                  pin_next.we_n = 1'b0;
               end
               else
               begin
                  state_next = ST_COL;
                  // Miss waits for the row fill into the cache
                  cnt_next = fast ? CACHE_LD : MISS_LD;
                  load = HIT_N;
                  pin_next.oe_n = 1'b0;
               end
            end
         end
         ST_COL:
         begin
            pin_next.latch_en = 1'b0;
            if (cnt_reg == 3'h0)
            begin
               state_next = ST_PAGE;
               rdata_next = DQ_IN;
               rsp_next = 1'b1;
               pin_next.latch_en = EDO_EN;
            end
         end
         ST_WRITE:
         begin
            if (cnt_reg == 3'h0)
            begin
               state_next = ST_PAGE;
               rsp_next = 1'b1;
               pin_next.cal_n = 1'b1;
               pin_next.we_n = 1'b1;
               pin_next.dq_oe = 1'b0;
            end
         end
         ST_PAGE:
         begin
            if (take)
            begin
               addr_next = REQ_ADDR;
               wdata_next = REQ_WDATA;
               pin_next.addr = {3'h0, REQ_ADDR[COL_W-1:0]};
               if (write_reg)
               begin
                  state_next = ST_WRITE;
                  cnt_next = CACHE_LD;
                  pin_next.dq = REQ_WDATA;
                  pin_next.dq_oe = 1'b1;
                  pin_next.cal_n = 1'b0;
                  pin_next.we_n = 1'b0;
               end
               else
               begin
                  state_next = ST_COL;
                  cnt_next = CACHE_LD;
               end
            end
            else
            begin
               // Strobe goes high at once; the page stays cached in the device
               state_next = ST_PRE;
               cnt_next = PRE_LD;
               pin_next = PINS_IDLE;
            end
         end
         ST_PRE:
         begin
            if (cnt_reg == 3'h0)
               state_next = ST_IDLE;
         end
         ST_REFRESH:
         begin
            if (cnt_reg == 3'h0)
            begin
               state_next = ST_PRE;
               cnt_next = PRE_LD;
               ack_next = 1'b1;
               pin_next = PINS_IDLE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
            pin_next = PINS_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 3'h0;
         addr_reg <= '0;
         wdata_reg <= 8'h00;
         write_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rsp_reg <= 1'b0;
         ack_reg <= 1'b0;
         pin_reg <= PINS_IDLE;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         write_reg <= write_next;
         rdata_reg <= rdata_next;
         rsp_reg <= rsp_next;
         ack_reg <= ack_next;
         pin_reg <= pin_next;
      end
   end

   assign RSP_VALID = rsp_reg;
   assign RSP_RDATA = rdata_reg;
   assign REFRESH_ACK = ack_reg;
   assign SEL_N = pin_reg.sel_n;
   assign ROW_STROBE_N = pin_reg.row_strobe_n;
   assign WR_SEL = pin_reg.wr;
   assign CAL_N = pin_reg.cal_n;
   assign WE_N = pin_reg.we_n;
   assign REFRESH_N = pin_reg.ref_n;
   assign OE_N = pin_reg.oe_n;
   assign LATCH_EN = pin_reg.latch_en;
   assign ADDR = pin_reg.addr;
   assign DQ_OUT = pin_reg.dq;
   assign DQ_OE = pin_reg.dq_oe;

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!rst_n);

   read_start_a: assert property ($fell(ROW_STROBE_N) && REFRESH_N
      |-> (!WR_SEL && state_reg == ST_ROW && !write_reg) ||
      (WR_SEL && CAL_N && WE_N)) else $error("Bad row strobe start");
   static_col_a: assert property (!ROW_STROBE_N && !WR_SEL |-> CAL_N)
      else $error("Column strobe low during read");
   write_gate_a: assert property (!WE_N |-> !CAL_N && WR_SEL && DQ_OE)
      else $error("Write enable without column strobe");
   oe_gate_a: assert property (!OE_N |-> !DQ_OE && !WR_SEL)
      else $error("Output enable during drive");
   miss_wait_a: assert property (state_reg == ST_ROW &&
      cnt_reg == 3'h0 && !write_reg && !fast
      |=> !RSP_VALID [*3] ##1 RSP_VALID) else $error("Miss wait wrong");
   hit_wait_a: assert property (state_reg == ST_ROW &&
      cnt_reg == 3'h0 && !write_reg && fast
      |=> !RSP_VALID [*2] ##1 RSP_VALID) else $error("Hit wait wrong");
   page_rate_a: assert property (state_reg == ST_PAGE && take
      |=> ##2 RSP_VALID) else $error("Page access not at cache rate");
   refresh_pulse_a: assert property ($fell(REFRESH_N)
      |-> !ROW_STROBE_N [*3] ##1 (ROW_STROBE_N && REFRESH_N && REFRESH_ACK))
      else $error("Refresh pulse wrong");
   edo_hold_a: assert property ($rose(LATCH_EN) |-> $past(EDO_EN) &&
      RSP_VALID && !OE_N) else $error("Latch engaged off read");
   no_write_load_a: assert property (trk.load |-> !write_reg)
      else $error("Tracker loaded on write");

   read_miss_c: cover property (state_reg == ST_ROW && !write_reg && !fast
      ##[1:4] RSP_VALID);
   read_hit_c: cover property (state_reg == ST_ROW && !write_reg && fast
      ##[1:4] RSP_VALID);
   page_read_c: cover property (state_reg == ST_PAGE && take && !write_reg);
   page_write_c: cover property (state_reg == ST_PAGE && take && write_reg);
   refresh_c: cover property (REFRESH_ACK);

endmodule

// ===== design/row_cache_pkg.sv
// Shared constants, types and decoders for the row-cache memory controller
package row_cache_pkg;

   // ***************************************
   // Address layout
   // ***************************************
   localparam int ADDR_W = 19;
   localparam int COL_W = 8;
   localparam int ROW_W = 11;
   localparam int ROW_LO = 8;
   localparam int BANK_LO = 8;
   localparam int NUM_BANKS = 4;
   localparam int LATCH_W = 9;
   localparam int DATA_W = 8;

   typedef logic [1:0] bank_t;
   typedef logic [LATCH_W-1:0] latch_t;
   typedef logic [ROW_W-1:0] row_t;

   // ***************************************
   // Timing
   // ***************************************
   typedef logic [2:0] cnt_t;
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_HIT_VALID_NS = 10;
   localparam int T_CACHE_NS = 12;
   localparam int T_MISS_NS = 30;
   localparam int T_PRECHARGE_NS = 20;
   localparam cnt_t HV_CYC =
      cnt_t'((T_HIT_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam cnt_t CACHE_CYC =
      cnt_t'((T_CACHE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam cnt_t MISS_CYC =
      cnt_t'((T_MISS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam cnt_t PRE_CYC =
      cnt_t'((T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam cnt_t HV_LD = HV_CYC - 3'h1;
   localparam cnt_t CACHE_LD = CACHE_CYC - 3'h1;
   localparam cnt_t MISS_LD = MISS_CYC - 3'h1;
   localparam cnt_t PRE_LD = PRE_CYC - 3'h1;

   // ***************************************
   // Device pins and states
   // ***************************************
   typedef struct packed {
      logic sel_n;
      logic row_strobe_n;
      logic wr;
      logic cal_n;
      logic we_n;
      logic ref_n;
      logic oe_n;
      logic latch_en;
      logic dq_oe;
      logic [ROW_W-1:0] addr;
      logic [DATA_W-1:0] dq;
   } pins_s;

   localparam pins_s PINS_IDLE = '{sel_n: 1'b1, row_strobe_n: 1'b1,
      wr: 1'b0, cal_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, oe_n: 1'b1,
      latch_en: 1'b0, dq_oe: 1'b0, addr: 11'h000, dq: 8'h00};

   typedef enum {ST_IDLE, ST_ROW, ST_COL, ST_WRITE, ST_PAGE, ST_PRE,
      ST_REFRESH} state_e;

   function automatic bank_t bank_of(input row_t row);
      return row[BANK_LO+1:BANK_LO];
   endfunction

   function automatic latch_t latch_of(input row_t row);
      return {row[ROW_W-1], row[BANK_LO-1:0]};
   endfunction

endpackage

// ===== design/row_track_if.sv
// Lookup and load signals between controller and row tracker
interface row_track_if;
   import row_cache_pkg::*;
   bank_t bank;
   latch_t row;
   logic load;
   logic hit;
   modport ctrl (output bank, output row, output load, input hit);
   modport trk (input bank, input row, input load, output hit);
endinterface

// ===== design/row_tracker.sv
// Per-bank mirror of the device's last-read row latches
module row_tracker
   import row_cache_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lookup and load
   row_track_if.trk trk
);

   logic [NUM_BANKS-1:0] hit_bank;

   // ***************************************
   // One latch per bank
   // ***************************************
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++)
      begin : g_bank
         logic valid_reg;
         logic valid_next;
         latch_t row_reg;
         latch_t row_next;

         always_comb
         begin
            valid_next = valid_reg;
            row_next = row_reg;
            if (trk.load && trk.bank == bank_t'(b))
            begin
               valid_next = 1'b1;
               row_next = trk.row;
            end
         end

         // Starts invalid, so the first read of each bank waits as a miss
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               valid_reg <= 1'b0;
               row_reg <= '0;
            end
            else
            begin
               valid_reg <= valid_next;
               row_reg <= row_next;
            end
         end

         assign hit_bank[b] = valid_reg && row_reg == trk.row;
      end
   endgenerate

   assign trk.hit = hit_bank[trk.bank];

   // ***************************************
   // Checks
   // ***************************************
   load_then_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
      trk.load ##1 ($stable(trk.bank) && $stable(trk.row)) |-> trk.hit)
      else $error("Loaded row not reported as hit");
   reset_miss_a: assert property (@(posedge clk)
      $rose(rst_n) |-> !trk.hit [*2])
      else $error("Hit predicted before any load");

endmodule

// ===== verification/row_cache_ctrl_bench.sv
// Self-checking bench for the row-cache memory controller
module row_cache_ctrl_bench
   import row_cache_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic wr; logic [18:0] a; logic [7:0] d; int lat;} row_s;
   logic clk, rst_n, req_valid, req_write, req_ready, rsp_valid;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq_in;
   logic refresh_req, edo_en, refresh_ack, sel_n, row_strobe_n, wr_sel;
   logic cal_n, we_n, refresh_n, oe_n, latch_en, dq_oe, hit_n;
   logic [ROW_W-1:0] addr;
   int refresh_cnt, proto_err, n_mismatch, checked, lat, n0, k;
   logic [7:0] ref_mem [int];
   row_s rows [16] = '{'{0, 19'h00112, 0, 5}, '{0, 19'h00134, 0, 3},
      '{1, 19'h00134, 8'h5A, 4}, '{0, 19'h00134, 0, 4},
      '{1, 19'h40134, 8'hA5, 4}, '{0, 19'h00134, 0, 4},
      '{0, 19'h40134, 0, 5}, '{0, 19'h10200, 0, 5},
      '{0, 19'h00134, 0, 5}, '{0, 19'h10255, 0, 4},
      '{1, 19'h10255, 8'h3C, 4}, '{1, 19'h10256, 8'hC3, 3},
      '{0, 19'h10256, 0, 4}, '{0, 19'h20000, 0, 5},
      '{0, 19'h30000, 0, 5}, '{0, 19'h10255, 0, 4}};

   row_cache_ctrl uut (.REF_CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
      .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
      .REFRESH_REQ(refresh_req), .EDO_EN(edo_en), .REFRESH_ACK(refresh_ack),
      .SEL_N(sel_n), .ROW_STROBE_N(row_strobe_n), .WR_SEL(wr_sel),
      .CAL_N(cal_n), .WE_N(we_n), .REFRESH_N(refresh_n), .OE_N(oe_n),
      .LATCH_EN(latch_en), .ADDR(addr), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .DQ_IN(dq_in), .HIT_N(hit_n));

   row_cache_device dev (.sel_n(sel_n), .row_strobe_n(row_strobe_n),
      .wr(wr_sel), .cal_n(cal_n), .we_n(we_n), .refresh_n(refresh_n),
      .oe_n(oe_n), .latch_en(latch_en), .addr(addr), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .hit_n(hit_n),
      .refresh_cnt(refresh_cnt), .proto_err(proto_err));

   // ***************************************
   // Shared tasks
   // ***************************************
   task automatic print_verdict();
      if (n_mismatch == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("BAD %s expected %0h seen %0h", what, exp, got);
         n_mismatch++;
      end
   endtask

   function automatic logic [7:0] ref_rd(input int a);
      if (ref_mem.exists(a))
         return ref_mem[a];
      return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
   endfunction

   // Entered at a falling edge; returns at the one showing the response
   task automatic access(input logic wr, input logic [18:0] a,
      input logic [7:0] d, output int n);
      int w;
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      // Let the ready logic see the new request before looking at it
      #1;
      w = 0;
      while (req_ready !== 1'b1 && w < 50)
      begin
         @(negedge clk);
         w++;
      end
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      // Count from the take edge, as the expected latencies do
      n = 1;
      while (rsp_valid !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   // ***************************************
   // Clock, watchdog and main sequence
   // ***************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #100us;
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      {rst_n, req_valid, req_write, refresh_req, edo_en} = 5'h00;
      req_addr = 19'h00000;
      req_wdata = 8'h00;
      n_mismatch = 0;
      checked = 0;
      repeat (6) @(negedge clk);
      check("idle pins", 12'hDE1,
         {sel_n, row_strobe_n, wr_sel, cal_n, we_n, refresh_n, oe_n,
         latch_en, dq_oe, rsp_valid, refresh_ack, req_ready});
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      foreach (rows[i])
      begin
         access(rows[i].wr, rows[i].a, rows[i].d, lat);
         check("latency", rows[i].lat, lat);
         if (rows[i].wr)
            ref_mem[rows[i].a] = rows[i].d;
         else
            check("read data", ref_rd(rows[i].a), rsp_rdata);
      end
      // Output latch engaged on a hit read
      edo_en = 1'b1;
      access(1'b0, 19'h30000, 8'h00, lat);
      check("edo latch", 1, latch_en);
      check("edo data", ref_rd(19'h30000), rsp_rdata);
      edo_en = 1'b0;
      // Refresh, then the cached page still hits
      @(negedge clk);
      n0 = refresh_cnt;
      refresh_req = 1'b1;
      k = 0;
      while (refresh_ack !== 1'b1 && k < 30)
      begin
         @(negedge clk);
         k++;
      end
      refresh_req = 1'b0;
      check("refresh ack", 1, refresh_ack);
      check("refresh count", n0 + 1, refresh_cnt);
      access(1'b0, 19'h10255, 8'h00, lat);
      check("hit after refresh", 4, lat);
      // Mid-run reset forgets the tracked rows
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      access(1'b0, 19'h10255, 8'h00, lat);
      check("latency after reset", 5, lat);
      check("data after reset", 8'h3C, rsp_rdata);
      repeat (4) @(negedge clk);
      check("pin protocol", 0, proto_err);
      print_verdict();
   end
endmodule

// ===== verification/row_cache_device.sv
// Behavioural model of the banked row-cache memory device
module row_cache_device
   import row_cache_pkg::*;
(
   // Control pins
   input wire logic sel_n,
   input wire logic row_strobe_n,
   input wire logic wr,
   input wire logic cal_n,
   input wire logic we_n,
   input wire logic refresh_n,
   input wire logic oe_n,
   input wire logic latch_en,
   input wire logic [ROW_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   // Data and status
   output logic [DATA_W-1:0] dq_in,
   output logic hit_n,
   // Observation
   output int refresh_cnt,
   output int proto_err
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] cache [NUM_BANKS][256];
   latch_t last_row [NUM_BANKS];
   logic row_ok [NUM_BANKS];
   row_t cur_row;
   bank_t cur_bank;
   logic cur_hit;
   logic fill_busy;
   logic [DATA_W-1:0] last_dq;

   function automatic logic [7:0] arr(input int a);
      if (mem.exists(a))
         return mem[a];
      return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
   endfunction

   initial
   begin
      for (int b = 0; b < NUM_BANKS; b++)
         row_ok[b] = 1'b0;
      refresh_cnt = 0;
      proto_err = 0;
      hit_n = 1'b1;
      fill_busy = 1'b0;
      last_dq = 8'h00;
      cur_bank = 2'h0;
      cur_hit = 1'b0;
   end

   // ***************************************
   // Row cycle start: compare and fill
   // ***************************************
   always @(negedge row_strobe_n)
   begin
      // Strobe, address and refresh pins switch in one step; let them settle
      #1;
      if (!refresh_n)
         refresh_cnt++;
      else if (sel_n)
         proto_err++;
      else
      begin
         cur_row = addr;
         cur_bank = bank_of(addr);
         cur_hit = row_ok[cur_bank] && last_row[cur_bank] == latch_of(addr);
         hit_n = !cur_hit;
         if (!wr && !cur_hit)
         begin
            for (int c = 0; c < 256; c++)
               cache[cur_bank][c] = arr({cur_row, c[7:0]});
            last_row[cur_bank] = latch_of(addr);
            row_ok[cur_bank] = 1'b1;
            // Miss data shows late, so a controller that rushes reads junk
            fill_busy = 1'b1;
            fill_busy <= #30 1'b0;
         end
      end
   end

   // Status pin is not held between cycles
   always @(posedge row_strobe_n)
      hit_n = ~hit_n;

   // ***************************************
   // Posted writes
   // ***************************************
   always @(cal_n or we_n or dq_out or addr or dq_oe or oe_n)
   begin
      // Pins of one edge land in any order; a stale row address would
      // otherwise be written, so sample once they have settled
      #1;
      if (!cal_n && !we_n && wr && !row_strobe_n)
      begin
         mem[{cur_row, addr[7:0]}] = dq_out;
         if (cur_hit)
            cache[cur_bank][addr[7:0]] = dq_out;
         if (!oe_n || !dq_oe)
            proto_err++;
      end
   end

   // ***************************************
   // Read data path, independent of the row strobe
   // ***************************************
   always @(addr or oe_n or sel_n or fill_busy or latch_en or cur_bank)
   begin
      if (latch_en)
         dq_in = dq_in;
      else if (oe_n || sel_n || fill_busy)
         dq_in = ~last_dq;
      else
      begin
         dq_in = cache[cur_bank][addr[7:0]];
         last_dq = dq_in;
      end
   end
endmodule
